// ---- hw/uif_funnel.v ----
// USB two-level interrupt funnel with Avalon-MM register slave
//
// Contract
// - All sources merge into one peripheral flag
// - Enables gate propagation only, flags still set
// - Status flag stays until software writes zero
// - Software writing one sets a status flag
// - Frame start token sets bit 6
// - Sent stall handshake sets bit 5
// - Bus idle 3 ms sets bit 4
// - Transaction done bit 3; clear advances FIFO (code advances only when sie_token_is_data_xfer is high)
// - D+/D- activity sets bit 2
// - Error summary is OR of enabled errors
// - Error summary is read-only, writes ignored
// - Bus reset sets bit 0, zeroes address
// - Status enables in bits 6..0, bit7 unused
// - Error flags set at once on detection
// - Bit stuffing violation sets error bit 7
// - Turnaround timeout sets error bit 4
// - Partial byte data field sets bit 3
// - Data CRC failure sets bit 2
// - Token CRC failure sets bit 1
// - Packet id failure sets bit 0
// - Errors clearable, reset zero, unused read zero
// - Error enables gate errors into summary
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "uif_defines.vh"
module uif_funnel #(
  parameter IDLE_CYCLES = `UIF_IDLE_CYCLES
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire sie_frame_start,
  input wire sie_stall_sent,
  input wire sie_line_idle,
  input wire sie_transaction_done,
  input wire sie_token_is_data_xfer,
  input wire sie_bus_activity,
  input wire sie_bus_reset,
  input wire sie_stuffing_error,
  input wire sie_turnaround_timeout,
  input wire sie_partial_byte_field,
  input wire sie_data_checksum_fail,
  input wire sie_token_checksum_fail,
  input wire sie_packet_id_fail,
  output reg usb_peripheral_irq_flag,
  output reg fifo_advance,
  output reg [6:0] device_address
);
  reg [7:0] status_flag_reg;
  reg [7:0] status_flag_next;
  reg [7:0] status_enable_reg;
  reg [7:0] error_flag_reg;
  reg [7:0] error_flag_next;
  reg [7:0] error_enable_reg;
  reg [7:0] status_enable_next;
  reg [7:0] error_enable_next;
  reg [31:0] idle_count_reg;
  reg idle_seen_reg;
  reg ack_pending_reg;
  reg [7:0] hw_status_set;
  reg [7:0] hw_error_set;
  reg [7:0] wr_byte;
  reg error_summary;
  reg advance_next;
  wire wr_hit;
  wire idle_reached;
  wire [31:0] idle_limit;

  // One wait cycle per access keeps read data registered
  assign wr_hit = avs_write && ack_pending_reg && avs_byteenable[0];
  assign idle_limit = IDLE_CYCLES;
  assign idle_reached = (idle_count_reg >= idle_limit - 32'h1);

  // Idle timer; only a continuous idle counts
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      idle_count_reg <= 32'h0;
      idle_seen_reg <= 1'b0;
    end else if (!sie_line_idle) begin
      idle_count_reg <= 32'h0;
      idle_seen_reg <= 1'b0;
    end else if (!idle_reached) begin
      idle_count_reg <= idle_count_reg + 32'h1;
    end else begin
      idle_seen_reg <= 1'b1;
    end
  end

  always @* begin
    wr_byte = avs_writedata[7:0];
    hw_status_set = 8'h00;
    hw_status_set[`UIF_BIT_FRAME_START] = sie_frame_start;
    hw_status_set[`UIF_BIT_STALL_SENT] = sie_stall_sent;
    hw_status_set[`UIF_BIT_BUS_IDLE] = idle_reached && sie_line_idle && !idle_seen_reg;
    hw_status_set[`UIF_BIT_TRANSACTION_DONE] = sie_transaction_done;
    hw_status_set[`UIF_BIT_BUS_ACTIVITY] = sie_bus_activity;
    hw_status_set[`UIF_BIT_BUS_RESET] = sie_bus_reset;
    hw_error_set = {sie_stuffing_error, 2'b00, sie_turnaround_timeout,
                    sie_partial_byte_field, sie_data_checksum_fail,
                    sie_token_checksum_fail, sie_packet_id_fail};
    // Status writes replace flags, error writes can only clear; hardware sets are ORed in after
    status_flag_next = status_flag_reg;
    error_flag_next = error_flag_reg;
    status_enable_next = status_enable_reg;
    error_enable_next = error_enable_reg;
    if (wr_hit && avs_address == `UIF_OFS_STATUS_FLAGS) begin
      status_flag_next = (status_flag_reg & ~`UIF_STATUS_SW_MASK) |
                         (wr_byte & `UIF_STATUS_SW_MASK);
    end
    if (wr_hit && avs_address == `UIF_OFS_ERROR_FLAGS) begin
      error_flag_next = error_flag_reg & wr_byte;
    end
    // Next enables, so a mask write never leaves a stale request a cycle
    if (wr_hit && avs_address == `UIF_OFS_STATUS_ENABLES) begin
      status_enable_next = wr_byte & `UIF_STATUS_MASK;
    end
    if (wr_hit && avs_address == `UIF_OFS_ERROR_ENABLES) begin
      error_enable_next = wr_byte & `UIF_ERROR_MASK;
    end
    status_flag_next = (status_flag_next | hw_status_set) & `UIF_STATUS_MASK;
    error_flag_next = (error_flag_next | hw_error_set) & `UIF_ERROR_MASK;
    // Error summary is pure status from enabled flags
    error_summary = |(error_flag_next & error_enable_next);
    status_flag_next[`UIF_BIT_ERROR_SUMMARY] = error_summary;
    // Advance only when a data token entry is popped by a clear
    advance_next = status_flag_reg[`UIF_BIT_TRANSACTION_DONE] &&
                   !status_flag_next[`UIF_BIT_TRANSACTION_DONE] &&
                   sie_token_is_data_xfer;
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      status_flag_reg <= `UIF_RESET_BYTE;
      error_flag_reg <= `UIF_RESET_BYTE;
      status_enable_reg <= `UIF_RESET_BYTE;
      error_enable_reg <= `UIF_RESET_BYTE;
      device_address <= `UIF_RESET_ADDR;
      usb_peripheral_irq_flag <= 1'b0;
      fifo_advance <= 1'b0;
      ack_pending_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      status_flag_reg <= status_flag_next;
      error_flag_reg <= error_flag_next;
      fifo_advance <= advance_next;
      status_enable_reg <= status_enable_next;
      error_enable_reg <= error_enable_next;
      // Any enabled status flag raises the CPU-side flag
      usb_peripheral_irq_flag <= |(status_flag_next & status_enable_next);
      // Bus reset wins over a software address write
      if (sie_bus_reset) begin
        device_address <= `UIF_RESET_ADDR;
      end else if (wr_hit && avs_address == `UIF_OFS_DEVICE_ADDRESS) begin
        device_address <= wr_byte[6:0];
      end
      // Two-cycle handshake: wait high on first cycle, low on second
      if ((avs_read || avs_write) && !ack_pending_reg) begin
        ack_pending_reg <= 1'b1;
        avs_waitrequest <= 1'b0;
        case (avs_address)
          `UIF_OFS_STATUS_FLAGS: avs_readdata <= {24'h0, status_flag_reg};
          `UIF_OFS_STATUS_ENABLES: avs_readdata <= {24'h0, status_enable_reg};
          `UIF_OFS_ERROR_FLAGS: avs_readdata <= {24'h0, error_flag_reg};
          `UIF_OFS_ERROR_ENABLES: avs_readdata <= {24'h0, error_enable_reg};
          `UIF_OFS_DEVICE_ADDRESS: avs_readdata <= {25'h0, device_address};
          default: avs_readdata <= 32'h0;
        endcase
      end else begin
        ack_pending_reg <= 1'b0;
        avs_waitrequest <= 1'b1;
      end
    end
  end
endmodule // uif_funnel

// ---- hw/uif_defines.vh ----
// Register offsets, field positions and reset values for the USB interrupt funnel
`ifndef UIF_DEFINES_VH
`define UIF_DEFINES_VH
`define UIF_OFS_STATUS_FLAGS 4'h0
`define UIF_OFS_STATUS_ENABLES 4'h1
`define UIF_OFS_ERROR_FLAGS 4'h2
`define UIF_OFS_ERROR_ENABLES 4'h3
`define UIF_OFS_DEVICE_ADDRESS 4'h4
`define UIF_BIT_FRAME_START 6
`define UIF_BIT_STALL_SENT 5
`define UIF_BIT_BUS_IDLE 4
`define UIF_BIT_TRANSACTION_DONE 3
`define UIF_BIT_BUS_ACTIVITY 2
`define UIF_BIT_ERROR_SUMMARY 1
`define UIF_BIT_BUS_RESET 0
`define UIF_STATUS_MASK 8'h7F
`define UIF_STATUS_SW_MASK 8'h7D
`define UIF_ERROR_MASK 8'h9F
`define UIF_RESET_BYTE 8'h00
`define UIF_RESET_ADDR 7'h00
`define UIF_IDLE_TIME_US 3000
`define UIF_CLK_MHZ 100
`define UIF_IDLE_CYCLES (`UIF_IDLE_TIME_US * `UIF_CLK_MHZ)
`endif

// ---- testbench/uif_funnel_asserts.sv ----
// Port-level assertions for the USB interrupt funnel
`timescale 1ns/1ps
module uif_funnel_chk (
  input wire sys_clk,
  input wire sys_rst,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire sie_bus_reset,
  input wire sie_token_is_data_xfer,
  input wire usb_peripheral_irq_flag,
  input wire fifo_advance,
  input wire [6:0] device_address
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  a_rd_upper: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_addr_zero: assert property (sie_bus_reset |=> device_address == 7'h00)
    else $error("address not zeroed by bus reset");
  a_addr_hold: assert property (!$stable(device_address) |->
    $past(avs_write || sie_bus_reset))
    else $error("address changed without cause");
  a_irq_sticky: assert property (usb_peripheral_irq_flag && !avs_write |=>
    usb_peripheral_irq_flag)
    else $error("request dropped without a write");
  a_adv_pulse: assert property (fifo_advance |=> !fifo_advance)
    else $error("advance pulse too long");
  a_adv_cause: assert property (fifo_advance |->
    $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("advance without a clearing write");
  a_adv_token: assert property (fifo_advance |-> $past(sie_token_is_data_xfer))
    else $error("advance for a non-data token");
endmodule // uif_funnel_chk
bind uif_funnel uif_funnel_chk i_chk (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .sie_bus_reset(sie_bus_reset),
  .sie_token_is_data_xfer(sie_token_is_data_xfer),
  .usb_peripheral_irq_flag(usb_peripheral_irq_flag),
  .fifo_advance(fifo_advance),
  .device_address(device_address)
);

// ---- testbench/uif_sie_model.sv ----
// Serial engine stand-in driving the event lines
`timescale 1ns/1ps
module uif_sie_model (
  input wire sys_clk,
  input wire [12:0] ev,
  output reg [12:0] sie
);
  // Index 8 inverted: queue head is a data token unless the bench says not
  always @(posedge sys_clk) begin
    sie <= ev ^ 13'h0100;
  end
endmodule // uif_sie_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the USB interrupt funnel
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, usb_peripheral_irq_flag;
  logic fifo_advance;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, r, rnd;
  logic [6:0] device_address;
  logic [12:0] ev, s;
  int n_errors, check_count, cyc, i;
  int evi[11] = '{12, 11, 9, 7, 6, 5, 4, 3, 2, 1, 0};
  int bt[11] = '{6, 5, 3, 2, 0, 7, 4, 3, 2, 1, 0};
  uif_sie_model i_sie (.sys_clk(sys_clk), .ev(ev), .sie(s));
  uif_funnel #(.IDLE_CYCLES(20)) i_dut (.*, .sie_frame_start(s[12]), .sie_stall_sent(s[11]),
    .sie_line_idle(s[10]), .sie_transaction_done(s[9]), .sie_token_is_data_xfer(s[8]),
    .sie_bus_activity(s[7]), .sie_bus_reset(s[6]), .sie_stuffing_error(s[5]),
    .sie_turnaround_timeout(s[4]), .sie_partial_byte_field(s[3]),
    .sie_data_checksum_fail(s[2]), .sie_token_checksum_fail(s[1]), .sie_packet_id_fail(s[0]));
  function logic [31:0] bitval(int b);
    return 32'h1 << b;
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    @(posedge sys_clk);
    while (avs_waitrequest) @(posedge sys_clk);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(r, e);
  endtask
  // Extra edge so the flag lands before the read is taken
  task pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge sys_clk);
    ev[k] <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task print_verdict();
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    {sys_rst, ev, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '1;
    {ev, avs_read, avs_write, avs_address, avs_writedata} = '0;
    void'($urandom(22));
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 6; i++) rdc(i[3:0], 32'h0);
    bus(1'b1, 4'h1, 8'hFF);
    rdc(4'h1, 32'h7F);
    bus(1'b1, 4'h3, 8'hFF);
    rdc(4'h3, 32'h9F);
    bus(1'b1, 4'h1, 8'h00);
    for (i = 0; i < 11; i++) begin
      pulse(evi[i]);
      chk(usb_peripheral_irq_flag, 32'h0);
      if (i < 5) rdc(4'h0, bitval(bt[i]));
      else rdc(4'h2, bitval(bt[i]));
      if (i > 4) rdc(4'h0, 32'h2);
      bus(1'b1, i > 4 ? 4'h2 : 4'h0, 8'h00);
      chk(fifo_advance, (i == 2) ? 32'h1 : 32'h0);
      rdc(4'h0, 32'h0);
    end
    bus(1'b1, 4'h3, 8'h00);
    pulse(5);
    rdc(4'h0, 32'h0);
    rdc(4'h2, 32'h80);
    bus(1'b1, 4'h2, 8'h00);
    ev[10] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rdc(4'h0, 32'h0);
    repeat (20) @(posedge sys_clk);
    rdc(4'h0, 32'h10);
    ev[10] <= 1'b0;
    bus(1'b1, 4'h1, 8'h7F);
    chk(usb_peripheral_irq_flag, 32'h1);
    bus(1'b1, 4'h0, 8'hFF);
    rdc(4'h0, 32'h7D);
    bus(1'b1, 4'h0, 8'h00);
    chk(fifo_advance, 32'h1);
    chk(usb_peripheral_irq_flag, 32'h0);
    ev[8] <= 1'b1;
    bus(1'b1, 4'h0, 8'h08);
    bus(1'b1, 4'h0, 8'h00);
    chk(fifo_advance, 32'h0);
    ev[8] <= 1'b0;
    bus(1'b1, 4'h4, 8'h55);
    rdc(4'h4, 32'h55);
    avs_byteenable <= 4'hE;
    bus(1'b1, 4'h4, 8'h2A);
    avs_byteenable <= 4'hF;
    rdc(4'h4, 32'h55);
    pulse(6);
    chk(device_address, 32'h0);
    rdc(4'h0, 32'h1);
    for (i = 0; i < 6; i++) begin
      rnd = $urandom;
      bus(1'b1, 4'h1, rnd[7:0]);
      rdc(4'h1, {24'h000000, rnd[7:0] & 8'h7F});
    end
    pulse(5);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 5; i++) rdc(i[3:0], 32'h0);
    chk(usb_peripheral_irq_flag, 32'h0);
    print_verdict();
  end
endmodule // tb_top
